/* File: sdds_ctrl.sv */
`timescale 1ns/1ns
`include "sdds_map.svh"
module sdds_ctrl
   import sdds_pkg::*;
(
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESETN_I,
   input  wire logic        MGMT_WR_I,
   input  wire logic        MGMT_RD_I,
   input  wire logic [4:0]  MGMT_ADDR_I,
   input  wire logic [15:0] MGMT_WDATA_I,
   input  wire logic        ENERGY_PAIR_A_I,
   input  wire logic        ENERGY_PAIR_B_I,
   output logic [15:0]      MGMT_RDATA_O,
   output logic             ENERGY_PRESENT_OUT_O,
   output logic             SLEEP_O,
   output logic             CORE_FUNC_EN_O
);
   typedef struct packed {
      logic [15:0] sleep_vol;
      logic [15:0] sleep_aon;
      logic [15:0] afe_vol;
      logic [15:0] afe_aon;
      sdds_state_t st;
      logic [15:0] rdata;
      logic        det;
      logic        slp;
      logic        func;
   } sdds_st_t;

   sdds_st_t  s_r;
   sdds_st_t  s_nxt;
   sdds_req_t req;
   logic      energy_ok;
   logic      raw_energy;
   logic      enabled;
   logic      cpu_mode;
   logic      slow_osc;
   logic      in_sleep;
   logic      awake;
   logic      rd_ok;
   logic      sleep_wr;
   logic      afe_wr;
   logic      copy_open;

   // ----------------------------------------
   // helpers
   // ----------------------------------------

   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [15:0] new_v,
                                         input logic [15:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction

   // address hit for one mapped register
   function automatic logic hit(input sdds_req_t  r,
                                input logic [4:0] a);
      hit = (r.addr == a);
   endfunction

   // read mux for mapped registers
   function automatic logic [15:0] rd_mux(input logic [4:0]  a,
                                          input logic [15:0] slp_v,
                                          input logic [15:0] afe_v);
      case (a)
         `SDDS_ADDR_SLEEP: rd_mux = slp_v;
         `SDDS_ADDR_AFE_B: rd_mux = afe_v;
         default:          rd_mux = `SDDS_RESET_VAL;
      endcase
   endfunction

   // pin level, forced high until enabled
   function automatic logic pin_lvl(input sdds_state_t st,
                                    input logic        ok,
                                    input logic        pol);
      pin_lvl = (st == SDDS_ST_FORCED) ? 1'b1 : (ok ^ pol);
   endfunction

   // ----------------------------------------
   // energy inputs and hold-off
   // ----------------------------------------

   // [R1] either pair counts
   assign raw_energy = ENERGY_PAIR_A_I | ENERGY_PAIR_B_I;
   assign req = '{wr: MGMT_WR_I, rd: MGMT_RD_I, addr: MGMT_ADDR_I, wdata: MGMT_WDATA_I};

   // [R23] parameterised hold-off
   sdds_deassert_timer u_tmr (
      .clk_i       (CLK_SYS_I),
      .resetn_i    (RESETN_I),
      .energy_i    (raw_energy),
      .extend_i    (s_r.sleep_aon[`SDDS_BIT_EXTEND]),
      .energy_ok_o (energy_ok)
   );

   // ----------------------------------------
   // decoded controls
   // ----------------------------------------
   // [R6] enable from always-on copy
   assign enabled   = s_r.sleep_aon[`SDDS_BIT_ENABLE];
   // [R2] method from always-on copy
   assign cpu_mode  = s_r.sleep_aon[`SDDS_BIT_METHOD];
   assign slow_osc  = s_r.afe_aon[`SDDS_BIT_SLOWOSC];
   assign in_sleep  = (s_r.st == SDDS_ST_SLEEP);
   // [R14] access kept with slow oscillator
   assign awake     = !in_sleep || slow_osc;
   assign rd_ok     = req.rd && awake;
   assign sleep_wr  = req.wr && awake && hit(req, `SDDS_ADDR_SLEEP);
   assign afe_wr    = req.wr && awake && hit(req, `SDDS_ADDR_AFE_B);
   // [R4] copy access gate
   assign copy_open = s_r.sleep_vol[`SDDS_BIT_COPY];

   // ----------------------------------------
   // register access
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      if (rd_ok) begin
         s_nxt.rdata = rd_mux(req.addr, s_r.sleep_vol, s_r.afe_vol);
      end
      if (sleep_wr) begin
         s_nxt.sleep_vol = req.wdata & `SDDS_SLEEP_MASK;
         // [R21] copies untouched without access
         if (copy_open || req.wdata[`SDDS_BIT_COPY]) begin
            s_nxt.sleep_aon = req.wdata & `SDDS_SLEEP_MASK;
         end
      end
      if (afe_wr) begin
         s_nxt.afe_vol = merge(s_r.afe_vol, req.wdata, `SDDS_AFE_MASK);
         if (copy_open) begin
            s_nxt.afe_aon = merge(s_r.afe_aon, req.wdata, `SDDS_AFE_MASK);
         end
      end

      // ----------------------------------------
      // sleep sequencing
      // ----------------------------------------
      case (s_r.st)
         SDDS_ST_FORCED: begin
            // [R6] enable bit starts function
            if (enabled) begin
               s_nxt.st = SDDS_ST_ACTIVE;
            end
         end
         SDDS_ST_ACTIVE: begin
            if (!enabled) begin
               s_nxt.st = SDDS_ST_FORCED;
            // [R2] method select
            end else if (cpu_mode) begin
               // [R3] manual entry
               if (sleep_wr && req.wdata[`SDDS_BIT_ENTER]) begin
                  s_nxt.st = SDDS_ST_SLEEP;
               end
            // [R17] automatic entry on loss
            end else if (!energy_ok) begin
               s_nxt.st = SDDS_ST_SLEEP;
            end
         end
         SDDS_ST_SLEEP: begin
            // [R14] write exits sleep
            if (sleep_wr) begin
               s_nxt.st = SDDS_ST_ACTIVE;
            // [R18] automatic wake
            end else if (!cpu_mode && energy_ok) begin
               s_nxt.st = SDDS_ST_ACTIVE;
            end
         end
         default: begin
            s_nxt.st = SDDS_ST_FORCED;
         end
      endcase

      // ----------------------------------------
      // pin and status
      // ----------------------------------------
      // [R8] [R9] [R11] forced, then energy with polarity
      s_nxt.det  = pin_lvl(s_nxt.st, energy_ok, s_r.sleep_aon[`SDDS_BIT_POL]);
      // [R22] sleep shuts core functions
      s_nxt.slp  = (s_nxt.st == SDDS_ST_SLEEP);
      s_nxt.func = (s_nxt.st != SDDS_ST_SLEEP);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // [R19] [R20] reset clears registers, sets pin and core enable high and exits sleep
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         s_r           <= '0;
         s_r.sleep_vol <= `SDDS_RESET_VAL;
         s_r.sleep_aon <= `SDDS_RESET_VAL;
         s_r.afe_vol   <= `SDDS_RESET_VAL;
         s_r.afe_aon   <= `SDDS_RESET_VAL;
         s_r.rdata     <= `SDDS_RESET_VAL;
         s_r.st        <= SDDS_ST_FORCED;
         s_r.det       <= 1'b1;
         s_r.slp       <= 1'b0;
         s_r.func      <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign MGMT_RDATA_O         = s_r.rdata;
   assign ENERGY_PRESENT_OUT_O = s_r.det;
   assign SLEEP_O              = s_r.slp;
   assign CORE_FUNC_EN_O       = s_r.func;
endmodule

/* File: sdds_map.svh */
`ifndef SDDS_MAP_SVH
`define SDDS_MAP_SVH
// Overview of operation
// [R1] output follows energy on either pair
// [R2] bit 6 selects cpu or automatic entry
// [R3] cpu method: bit 5 enters sleep
// [R4] bit 4 opens the always-on copies
// [R5] host sets bit 4 with bit 3
// [R6] bit 3 enables sleep and output
// [R7] bit 1 lengthens deassert and entry delay
// [R8] bit 0 picks output polarity
// [R9] before enable output forced high
// [R10] host writes 0x0058 for cpu method
// [R11] once enabled output follows energy
// [R12] host sets bit 5 on deassert
// [R13] host wakes by supply, reset, rewrite
// [R14] slow oscillator keeps access, write exits
// [R15] host writes 0x001a or 0x0018 automatic
// [R16] host sets bit 1 except special link
// [R17] automatic: loss enters sleep, deasserts
// [R18] automatic: energy asserts and wakes
// [R19] hardware reset always exits sleep
// [R20] copies survive sleep, cleared by reset
// [R21] without bit 4 copies stay unchanged
// [R22] sleep disables all but detect output
// [R23] delays are parameters, extended longer

// ----------------------------------------
// register addresses and fields
// ----------------------------------------
`define SDDS_ADDR_AFE_B     5'h13
`define SDDS_ADDR_SLEEP     5'h14
`define SDDS_BIT_METHOD     6
`define SDDS_BIT_ENTER      5
`define SDDS_BIT_COPY       4
`define SDDS_BIT_ENABLE     3
`define SDDS_BIT_EXTEND     1
`define SDDS_BIT_POL        0
`define SDDS_BIT_SLOWOSC    0
`define SDDS_SLEEP_MASK     16'h007b
`define SDDS_AFE_MASK       16'h0303
`define SDDS_RESET_VAL      16'h0000

// ----------------------------------------
// deassert delays
// ----------------------------------------
`define SDDS_DLY_DEF_NS     1000
`define SDDS_DLY_EXT_NS     4000
`define SDDS_CLK_NS         10
`define SDDS_DLY_DEF_CYC    (`SDDS_DLY_DEF_NS / `SDDS_CLK_NS)
`define SDDS_DLY_EXT_CYC    (`SDDS_DLY_EXT_NS / `SDDS_CLK_NS)
`define SDDS_CNT_W          12
`endif

/* File: sdds_pkg.sv */
package sdds_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } sdds_req_t;

   typedef enum logic [2:0] {
      SDDS_ST_FORCED = 3'b001,
      SDDS_ST_ACTIVE = 3'b010,
      SDDS_ST_SLEEP  = 3'b100
   } sdds_state_t;

   typedef struct packed {
      logic [15:0] data;
      logic        en;
   } sdds_ctr_in_t;
endpackage

/* File: sdds_deassert_timer.sv */
`timescale 1ns/1ns
`include "sdds_map.svh"
module sdds_deassert_timer
   import sdds_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  resetn_i,
   input  wire logic  energy_i,
   input  wire logic  extend_i,
   output logic       energy_ok_o
);
   typedef struct packed {
      logic [`SDDS_CNT_W-1:0] cnt;
      logic                   ok;
   } sdds_tmr_t;

   sdds_tmr_t s_r;
   sdds_tmr_t s_nxt;
   logic [`SDDS_CNT_W-1:0] lim;

   // ----------------------------------------
   // hold-off before loss is declared
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      // [R7] extended delay select
      lim = extend_i ? `SDDS_CNT_W'(`SDDS_DLY_EXT_CYC) : `SDDS_CNT_W'(`SDDS_DLY_DEF_CYC);
      if (energy_i) begin
         s_nxt.cnt = '0;
         s_nxt.ok  = 1'b1;
      end else if (s_r.ok) begin
         if (s_r.cnt >= lim - `SDDS_CNT_W'(1)) begin
            s_nxt.ok  = 1'b0;
            s_nxt.cnt = '0;
         end else begin
            s_nxt.cnt = s_r.cnt + `SDDS_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign energy_ok_o = s_r.ok;
endmodule

/* File: sdds_ctrl_props.sv */
`timescale 1ns/1ns
module sdds_ctrl_props
   import sdds_pkg::*;
(
   input logic        CLK_SYS_I,
   input logic        RESETN_I,
   input logic        MGMT_WR_I,
   input logic        MGMT_RD_I,
   input logic [4:0]  MGMT_ADDR_I,
   input logic [15:0] MGMT_WDATA_I,
   input logic        ENERGY_PAIR_A_I,
   input logic        ENERGY_PAIR_B_I,
   input logic [15:0] MGMT_RDATA_O,
   input logic        ENERGY_PRESENT_OUT_O,
   input logic        SLEEP_O,
   input logic        CORE_FUNC_EN_O
);
   logic       en_r, m_r, x_r, p_r;
   logic [2:0] qc_r;
   logic [8:0] lo_r;
   wire        e  = ENERGY_PAIR_A_I | ENERGY_PAIR_B_I;
   wire        w4 = MGMT_WR_I && MGMT_ADDR_I == 5'h14 && MGMT_WDATA_I[4] && !SLEEP_O;
   wire        ok = en_r && qc_r == 3'h7;
   wire        dl = lo_r == (x_r ? 9'h19a : 9'h06e);
   // ----------------------------------------
   // config shadow and loss counter
   // ----------------------------------------
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         {m_r, en_r, x_r, p_r} <= 4'h0;
         qc_r <= 3'h0;
         lo_r <= 9'h000;
      end else begin
         if (w4) {m_r, en_r, x_r, p_r} <= {MGMT_WDATA_I[6], MGMT_WDATA_I[3], MGMT_WDATA_I[1:0]};
         qc_r <= w4 ? 3'h0 : qc_r + {2'h0, qc_r != 3'h7};
         lo_r <= e ? 9'h000 : lo_r + {8'h00, lo_r != 9'h1ff};
      end
   end
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   a_core_gate: assert property (CORE_FUNC_EN_O == !SLEEP_O)
      else $error("core enable wrong");
   a_forced_high: assert property (!en_r && qc_r == 3'h7 |-> ENERGY_PRESENT_OUT_O)
      else $error("pin not forced");
   a_follow_energy: assert property ((ok && e)[*6] |-> ENERGY_PRESENT_OUT_O != p_r)
      else $error("pin not asserted");
   a_loss_deassert: assert property (ok && dl |-> ENERGY_PRESENT_OUT_O == p_r)
      else $error("pin not deasserted");
   a_auto_sleep: assert property (ok && !m_r && dl |-> SLEEP_O)
      else $error("no auto sleep");
   a_auto_wake: assert property (ok && !m_r && SLEEP_O && e |-> ##[1:4] !SLEEP_O)
      else $error("no auto wake");
   a_cpu_enter: assert property (en_r && m_r && w4 && MGMT_WDATA_I[6:3] == 4'hf |-> ##[1:3] SLEEP_O)
      else $error("no cpu sleep");
   a_rdata_hold: assert property (!MGMT_RD_I |=> $stable(MGMT_RDATA_O))
      else $error("read data moved");
   cover property (SLEEP_O && !m_r);
   cover property (SLEEP_O && m_r);
   cover property (ok && x_r && dl);
endmodule
bind sdds_ctrl sdds_ctrl_props u_props (.*);

/* File: sdds_host_model.sv */
`timescale 1ns/1ns
module sdds_host_model
   import sdds_pkg::*;
(
   input  logic        clk_i,
   input  logic        pin_i,
   input  logic [15:0] rdata_i,
   output sdds_req_t   req_o
);
   logic react_r = 1'b0;
   initial req_o = '0;
   always @(negedge pin_i) begin
      if (react_r) wr(5'h14, 16'h0078);
   end
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk_i);
      #1 req_o <= '{1'b1, 1'b0, a, v};
      @(posedge clk_i);
      #1 req_o.wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge clk_i);
      #1 req_o <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk_i);
      #1 req_o.rd <= 1'b0;
      v = rdata_i;
   endtask
endmodule

/* File: sdds_ctrl_tb.sv */
`timescale 1ns/1ns
module sdds_ctrl_tb
   import sdds_pkg::*;
;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        ea = 1'b0;
   logic        eb = 1'b0;
   logic        pin, slp, core;
   logic [15:0] rdata, d;
   sdds_req_t   req;
   int          num_errors = 0;
   int          total_checks = 0;
   sdds_ctrl uut (.CLK_SYS_I(clk), .RESETN_I(resetn), .MGMT_WR_I(req.wr),
      .MGMT_RD_I(req.rd), .MGMT_ADDR_I(req.addr), .MGMT_WDATA_I(req.wdata),
      .ENERGY_PAIR_A_I(ea), .ENERGY_PAIR_B_I(eb), .MGMT_RDATA_O(rdata),
      .ENERGY_PRESENT_OUT_O(pin), .SLEEP_O(slp), .CORE_FUNC_EN_O(core));
   sdds_host_model host (.clk_i(clk), .pin_i(pin), .rdata_i(rdata), .req_o(req));
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic chs(input logic [2:0] exp);
      chk({13'h0000, pin, slp, core}, {13'h0000, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_regs();
      host.wr(5'h14, 16'h0008);
      cyc(150);
      chs(3'b101);
      host.rd(5'h14, d);
      chk(d, 16'h0008);
      ea = 1'b1;
      host.wr(5'h14, 16'h0019);
      host.wr(5'h13, 16'hffff);
      host.rd(5'h14, d);
      chk(d, 16'h0019);
      host.rd(5'h13, d);
      chk(d, 16'h0303);
      host.rd(5'h07, d);
      chk(d, 16'h0000);
      chs(3'b001);
      ea = 1'b0;
      cyc(150);
      chs(3'b110);
      ea = 1'b1;
      cyc(6);
      chs(3'b001);
   endtask
   task automatic t_ext();
      eb = 1'b1;
      ea = 1'b0;
      host.wr(5'h14, 16'h001a);
      cyc(10);
      eb = 1'b0;
      cyc(300);
      chs(3'b101);
      cyc(150);
      chs(3'b010);
      resetn = 1'b0;
      cyc(2);
      chs(3'b101);
      resetn = 1'b1;
      host.rd(5'h14, d);
      chk(d, 16'h0000);
   endtask
   task automatic t_cpu();
      ea = 1'b1;
      host.wr(5'h14, 16'h0058);
      host.wr(5'h13, 16'h0001);
      host.react_r = 1'b1;
      cyc(10);
      ea = 1'b0;
      cyc(150);
      chs(3'b010);
      ea = 1'b1;
      cyc(10);
      chs(3'b110);
      host.wr(5'h14, 16'h0058);
      cyc(4);
      chs(3'b101);
      host.react_r = 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      cyc(16);
      resetn = 1'b1;
      t_regs();
      $display("regs done");
      t_ext();
      $display("ext done");
      t_cpu();
      $display("cpu done");
      report_and_stop();
   end
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end
endmodule
